/* File: logic/usb_setup_cfg.svh */
// offsets, field positions, bit masks and frame timing for the setup capture and interrupt block
`ifndef USB_SETUP_CFG_SVH
`define USB_SETUP_CFG_SVH

`define OFS_SETUP_VALUE    12'h000
`define OFS_SETUP_INDEX    12'h004
`define OFS_SETUP_LENGTH   12'h008
`define OFS_INT_FLAGS      12'h00C
`define OFS_NAK_RECORD     12'h010
`define OFS_EP_RECORD      12'h014
`define OFS_IRQ_MASK       12'h018

`define BIT_M_NAK          15
`define BIT_M_EP           14
`define BIT_EP0_DONE_LINE_MASK          13
`define BIT_M_SOF          12
`define BIT_I_NAK          7
`define BIT_I_EP           6
`define BIT_EP0_DONE_FLAG          5
`define BIT_I_SOF          4

`define FLAG_BITS_MASK     8'hF0
`define MASK_BITS_MASK     8'hF0
`define WORD_ZERO          32'h0000_0000
`define NUM_EP             4

// one full-speed frame is 1 ms
`define FRAME_TIME_US      1000
`define CLK_MHZ            100
`define FRAME_CYCLES       (`FRAME_TIME_US * `CLK_MHZ)

`endif

/* File: logic/usb_setup_pkg.sv */
// types shared by the setup capture and interrupt block
package usb_setup_pkg;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_s;

   typedef struct packed {
      logic       setup_byte_valid;
      logic [2:0] setup_byte_index;
      logic [7:0] setup_byte;
      logic       setup_ok;
      logic       ep0_done;
      logic       ep_done;
      logic [3:0] ep_done_num;
      logic       nak_sent;
      logic [3:0] nak_ep_num;
      logic       sof_rx;
      logic       create_sof;
   } link_evt_s;

   typedef struct packed {
      logic nak_line;
      logic ep_line;
      logic ep0_line;
      logic sof_line;
   } irq_lines_s;

endpackage : usb_setup_pkg

/* File: logic/usb_setup_capture_int_mask.sv */
// setup packet capture, interrupt flags and line masks with an apb register port
//
// Notes on behaviour
// - setup byte four lands in bits 15:8 of the value register
// - setup byte three lands in bits 7:0 of the value register
// - setup byte six lands in bits 15:8 of the index register
// - setup byte five lands in bits 7:0 of the index register
// - setup byte eight lands in bits 15:8 of the length register
// - setup byte seven lands in bits 7:0 of the length register
// - mask bit 15 set keeps the nak flag off its line
// - mask bit 14 set keeps the endpoint done flag off its line
// - mask bit 13 set keeps the ep0 done flag off its line
// - flag bit 5 sets when an ep0 transfer completes
// - flag bit 7 sets on nak from non-ep0; writing one clears nak record
// - flag bit 4 sets on sof or each counted frame in create mode
`timescale 1ns/1ns
`default_nettype none
`include "usb_setup_cfg.svh"

module usb_setup_capture_int_mask
   import usb_setup_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire apb_req_s    apb_req,
   output var  apb_rsp_s    apb_rsp,
   input  wire link_evt_s   link_evt,
   output var  irq_lines_s  irq_lines,
   output logic             irq
);

   typedef struct packed {
      logic [15:0]  value;
      logic [15:0]  index;
      logic [15:0]  length;
      logic [47:0]  shadow;
      logic [7:0]   flags;
      logic [7:0]   masks;
      logic [3:0]   nak_rec;
      logic [3:0]   ep_rec;
      logic [7:0]   irq_en;
      logic [16:0]  frame_cnt;
      apb_rsp_s     rsp;
      irq_lines_s   lines;
      logic         irq;
   } state_s;

   state_s s_q;
   state_s s_d;

   logic        wr_acc;
   logic        rd_acc;
   logic [31:0] rd_word;
   logic        frame_tick;
   logic [7:0]  set_flags;
   logic [7:0]  clr_flags;
   logic        flags_wr;

   assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign rd_acc = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
   assign flags_wr = wr_acc && (apb_req.paddr == `OFS_INT_FLAGS);

   // -----------------------------------------------------------------
   // read mux
   // -----------------------------------------------------------------
   always_comb begin
      case (apb_req.paddr)
         `OFS_SETUP_VALUE:  rd_word = {16'h0000, s_q.value};
         `OFS_SETUP_INDEX:  rd_word = {16'h0000, s_q.index};
         `OFS_SETUP_LENGTH: rd_word = {16'h0000, s_q.length};
         `OFS_INT_FLAGS:    rd_word = {16'h0000, s_q.masks, s_q.flags};
         `OFS_NAK_RECORD:   rd_word = {28'h000_0000, s_q.nak_rec};
         `OFS_EP_RECORD:    rd_word = {28'h000_0000, s_q.ep_rec};
         `OFS_IRQ_MASK:     rd_word = {24'h00_0000, s_q.irq_en};
         default:           rd_word = `WORD_ZERO;
      endcase
   end

   assign frame_tick = link_evt.create_sof && (s_q.frame_cnt == 17'(`FRAME_CYCLES - 1));

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      set_flags = 8'h00;
      clr_flags = 8'h00;

      // apb: zero-wait slave; read data registered in setup, ready in access
      s_d.rsp.pready  = apb_req.psel && !apb_req.penable;
      s_d.rsp.pslverr = 1'b0;
      if (rd_acc) begin
         s_d.rsp.prdata = rd_word;
      end
      if (apb_req.psel && apb_req.penable) begin
         s_d.rsp.pready = 1'b0;
      end

      // frame counter only runs while the block makes its own sof
      if (!link_evt.create_sof || frame_tick) begin
         s_d.frame_cnt = 17'h0_0000;
      end else begin
         s_d.frame_cnt = s_q.frame_cnt + 17'h0_0001;
      end

      // byte 0 of the shadow is setup byte three; commit only on good setup
      if (link_evt.setup_byte_valid && link_evt.setup_byte_index >= 3'h2) begin
         case (link_evt.setup_byte_index)
            3'h2:    s_d.shadow[7:0]   = link_evt.setup_byte;
            3'h3:    s_d.shadow[15:8]  = link_evt.setup_byte;
            3'h4:    s_d.shadow[23:16] = link_evt.setup_byte;
            3'h5:    s_d.shadow[31:24] = link_evt.setup_byte;
            3'h6:    s_d.shadow[39:32] = link_evt.setup_byte;
            default: s_d.shadow[47:40] = link_evt.setup_byte;
         endcase
      end
      if (link_evt.setup_ok) begin
         s_d.value[15:8]  = s_q.shadow[15:8];
         s_d.value[7:0]   = s_q.shadow[7:0];
         s_d.index[15:8]  = s_q.shadow[31:24];
         s_d.index[7:0]   = s_q.shadow[23:16];
         s_d.length[15:8] = s_q.shadow[47:40];
         s_d.length[7:0]  = s_q.shadow[39:32];
      end

      set_flags[`BIT_EP0_DONE_FLAG] = link_evt.ep0_done;
      set_flags[`BIT_I_NAK] = link_evt.nak_sent && link_evt.nak_ep_num != 4'h0;
      set_flags[`BIT_I_EP]  = link_evt.ep_done && link_evt.ep_done_num != 4'h0;
      set_flags[`BIT_I_SOF] = link_evt.sof_rx || frame_tick;

      if (wr_acc) begin
         case (apb_req.paddr)
            `OFS_INT_FLAGS: begin
               clr_flags = apb_req.pwdata[7:0] & `FLAG_BITS_MASK;
               s_d.masks = apb_req.pwdata[15:8] & `MASK_BITS_MASK;
               if (apb_req.pwdata[`BIT_I_NAK]) begin
                  s_d.nak_rec = 4'h0;
               end
               if (apb_req.pwdata[`BIT_I_EP]) begin
                  s_d.ep_rec = 4'h0;
               end
            end
            `OFS_IRQ_MASK: s_d.irq_en = apb_req.pwdata[7:0] & `FLAG_BITS_MASK;
            default: ;
         endcase
      end

      // a new event beats a clear in the same cycle
      if (set_flags[`BIT_I_NAK]) begin
         s_d.nak_rec[link_evt.nak_ep_num[1:0]] = 1'b1;
      end
      if (set_flags[`BIT_I_EP]) begin
         s_d.ep_rec[link_evt.ep_done_num[1:0]] = 1'b1;
      end
      s_d.flags = (s_q.flags & ~clr_flags) | set_flags;

      s_d.lines.nak_line = s_q.flags[`BIT_I_NAK] && !s_q.masks[`BIT_M_NAK - 8];
      s_d.lines.ep_line  = s_q.flags[`BIT_I_EP]  && !s_q.masks[`BIT_M_EP - 8];
      s_d.lines.ep0_line = s_q.flags[`BIT_EP0_DONE_FLAG] && !s_q.masks[`BIT_EP0_DONE_LINE_MASK - 8];
      s_d.lines.sof_line = s_q.flags[`BIT_I_SOF] && !s_q.masks[`BIT_M_SOF - 8];
      s_d.irq = |(s_q.flags & s_q.irq_en);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign apb_rsp   = s_q.rsp;
   assign irq_lines = s_q.lines;
   assign irq       = s_q.irq;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_value_high_byte: assert property (@(posedge clk) disable iff (reset)
      link_evt.setup_ok |=> s_q.value[15:8] == $past(s_q.shadow[15:8]))
      else $error("value high byte not captured");
   a_value_low_byte: assert property (@(posedge clk) disable iff (reset)
      link_evt.setup_ok |=> s_q.value[7:0] == $past(s_q.shadow[7:0]))
      else $error("value low byte not captured");
   a_index_high_byte: assert property (@(posedge clk) disable iff (reset)
      link_evt.setup_ok |=> s_q.index[15:8] == $past(s_q.shadow[31:24]))
      else $error("index high byte not captured");
   a_index_low_byte: assert property (@(posedge clk) disable iff (reset)
      link_evt.setup_ok |=> s_q.index[7:0] == $past(s_q.shadow[23:16]))
      else $error("index low byte not captured");
   a_length_high_byte: assert property (@(posedge clk) disable iff (reset)
      link_evt.setup_ok |=> s_q.length[15:8] == $past(s_q.shadow[47:40]))
      else $error("length high byte not captured");
   a_length_low_byte: assert property (@(posedge clk) disable iff (reset)
      link_evt.setup_ok |=> s_q.length[7:0] == $past(s_q.shadow[39:32]))
      else $error("length low byte not captured");
   a_nak_line_gate: assert property (@(posedge clk) disable iff (reset)
      irq_lines.nak_line |-> $past(s_q.flags[7]) && !$past(s_q.masks[7]))
      else $error("nak line active while masked or idle");
   a_ep_line_gate: assert property (@(posedge clk) disable iff (reset)
      $past(s_q.flags[6]) && !$past(s_q.masks[6]) |-> irq_lines.ep_line)
      else $error("endpoint done line missing");
   a_ep0_line_gate: assert property (@(posedge clk) disable iff (reset)
      irq_lines.ep0_line == ($past(s_q.flags[5]) && !$past(s_q.masks[5])))
      else $error("ep0 line gating wrong");
   a_ep0_flag_set: assert property (@(posedge clk) disable iff (reset)
      link_evt.ep0_done |=> s_q.flags[5] ##1 (irq_lines.ep0_line || $past(s_q.masks[5])))
      else $error("ep0 done flag not set");
   a_nak_flag_set: assert property (@(posedge clk) disable iff (reset)
      link_evt.nak_sent && link_evt.nak_ep_num != 4'h0 |=> s_q.flags[7] && s_q.nak_rec != 4'h0)
      else $error("nak flag not set");
   a_sof_flag_set: assert property (@(posedge clk) disable iff (reset)
      link_evt.sof_rx |=> s_q.flags[4])
      else $error("frame flag not set");
   a_capture_hold: assert property (@(posedge clk) disable iff (reset)
      !link_evt.setup_ok |=> $stable(s_q.value) && $stable(s_q.index) && $stable(s_q.length))
      else $error("captured words changed without setup");

   // -----------------------------------------------------------------
   // bus checks
   // -----------------------------------------------------------------
   a_pready_setup: assert property (@(posedge clk) disable iff (reset)
      apb_req.psel && !apb_req.penable
      |=> apb_rsp.pready)
      else $error("pready missing in access phase");
   a_pready_pulse: assert property (@(posedge clk) disable iff (reset)
      apb_rsp.pready
      |=> !apb_rsp.pready)
      else $error("pready held longer than one cycle");
   a_pready_access: assert property (@(posedge clk) disable iff (reset)
      apb_rsp.pready
      |-> apb_req.psel && apb_req.penable)
      else $error("pready outside an access phase");
   a_rdata_load: assert property (@(posedge clk) disable iff (reset)
      rd_acc
      |=> apb_rsp.prdata == $past(rd_word))
      else $error("read data not loaded in setup phase");
   a_rdata_hold: assert property (@(posedge clk) disable iff (reset)
      !rd_acc
      |=> $stable(apb_rsp.prdata))
      else $error("read data changed without a read");
   a_no_slave_error: assert property (@(posedge clk) disable iff (reset)
      !apb_rsp.pslverr)
      else $error("slave error raised");

   // -----------------------------------------------------------------
   // register checks
   // -----------------------------------------------------------------
   a_mask_write: assert property (@(posedge clk) disable iff (reset)
      flags_wr
      |=> s_q.masks == ($past(apb_req.pwdata[15:8]) & `MASK_BITS_MASK))
      else $error("mask bits not written");
   a_irq_en_write: assert property (@(posedge clk) disable iff (reset)
      wr_acc && apb_req.paddr == `OFS_IRQ_MASK
      |=> s_q.irq_en == ($past(apb_req.pwdata[7:0]) & `FLAG_BITS_MASK))
      else $error("interrupt enable not written");
   a_low_bits_zero: assert property (@(posedge clk) disable iff (reset)
      s_q.flags[3:0] == 4'h0 && s_q.masks[3:0] == 4'h0 && s_q.irq_en[3:0] == 4'h0)
      else $error("unimplemented flag or mask bit set");
   a_reset_clears: assert property (@(posedge clk)
      reset
      |=> s_q.value == 16'h0000 && s_q.index == 16'h0000 && s_q.length == 16'h0000)
      else $error("captured words not cleared by reset");

   // -----------------------------------------------------------------
   // flag checks
   // -----------------------------------------------------------------
   a_nak_flag_clear: assert property (@(posedge clk) disable iff (reset)
      flags_wr && apb_req.pwdata[`BIT_I_NAK] && !set_flags[`BIT_I_NAK]
      |=> !s_q.flags[`BIT_I_NAK])
      else $error("nak flag not cleared by writing one");
   a_nak_record_clear: assert property (@(posedge clk) disable iff (reset)
      flags_wr && apb_req.pwdata[`BIT_I_NAK] && !set_flags[`BIT_I_NAK]
      |=> s_q.nak_rec == 4'h0)
      else $error("nak record not cleared");
   a_nak_flag_sticky: assert property (@(posedge clk) disable iff (reset)
      s_q.flags[`BIT_I_NAK] && !(flags_wr && apb_req.pwdata[`BIT_I_NAK])
      |=> s_q.flags[`BIT_I_NAK])
      else $error("nak flag dropped without a clear");
   a_nak_ep0_ignored: assert property (@(posedge clk) disable iff (reset)
      link_evt.nak_sent && link_evt.nak_ep_num == 4'h0 && !s_q.flags[`BIT_I_NAK]
      |=> !s_q.flags[`BIT_I_NAK])
      else $error("nak on ep0 set the nak flag");
   a_ep_flag_set: assert property (@(posedge clk) disable iff (reset)
      link_evt.ep_done && link_evt.ep_done_num != 4'h0
      |=> s_q.flags[`BIT_I_EP] && s_q.ep_rec != 4'h0)
      else $error("endpoint done flag not set");
   a_ep_record_clear: assert property (@(posedge clk) disable iff (reset)
      flags_wr && apb_req.pwdata[`BIT_I_EP] && !set_flags[`BIT_I_EP]
      |=> s_q.ep_rec == 4'h0)
      else $error("endpoint record not cleared");
   a_ep0_flag_clear: assert property (@(posedge clk) disable iff (reset)
      flags_wr && apb_req.pwdata[`BIT_EP0_DONE_FLAG] && !set_flags[`BIT_EP0_DONE_FLAG]
      |=> !s_q.flags[`BIT_EP0_DONE_FLAG])
      else $error("ep0 flag not cleared by writing one");
   a_ep0_flag_sticky: assert property (@(posedge clk) disable iff (reset)
      s_q.flags[`BIT_EP0_DONE_FLAG] && !(flags_wr && apb_req.pwdata[`BIT_EP0_DONE_FLAG])
      |=> s_q.flags[`BIT_EP0_DONE_FLAG])
      else $error("ep0 flag dropped without a clear");

   // -----------------------------------------------------------------
   // frame and line checks
   // -----------------------------------------------------------------
   // a full frame takes too long to run in a test, so the counter is watched here
   a_frame_flag_set: assert property (@(posedge clk) disable iff (reset)
      frame_tick
      |=> s_q.flags[`BIT_I_SOF])
      else $error("frame flag not set at frame end");
   a_frame_count_idle: assert property (@(posedge clk) disable iff (reset)
      !link_evt.create_sof
      |=> s_q.frame_cnt == 17'h0_0000)
      else $error("frame counter runs outside create mode");
   a_frame_count_range: assert property (@(posedge clk) disable iff (reset)
      s_q.frame_cnt < 17'(`FRAME_CYCLES))
      else $error("frame counter past one frame");
   a_sof_line_gate: assert property (@(posedge clk) disable iff (reset)
      irq_lines.sof_line == ($past(s_q.flags[4]) && !$past(s_q.masks[4])))
      else $error("sof line gating wrong");
   a_irq_level: assert property (@(posedge clk) disable iff (reset)
      irq == |($past(s_q.flags) & $past(s_q.irq_en)))
      else $error("interrupt level wrong");
   a_nak_line_open: assert property (@(posedge clk) disable iff (reset)
      $past(s_q.flags[7]) && !$past(s_q.masks[7])
      |-> irq_lines.nak_line)
      else $error("nak line missing while open");
   a_ep_line_quiet: assert property (@(posedge clk) disable iff (reset)
      irq_lines.ep_line
      |-> $past(s_q.flags[6]) && !$past(s_q.masks[6]))
      else $error("endpoint done line active while masked or idle");

   // -----------------------------------------------------------------
   // shadow checks
   // -----------------------------------------------------------------
   a_shadow_first: assert property (@(posedge clk) disable iff (reset)
      link_evt.setup_byte_valid && link_evt.setup_byte_index == 3'h2
      |=> s_q.shadow[7:0] == $past(link_evt.setup_byte))
      else $error("setup byte three not shadowed");
   a_shadow_last: assert property (@(posedge clk) disable iff (reset)
      link_evt.setup_byte_valid && link_evt.setup_byte_index == 3'h7
      |=> s_q.shadow[47:40] == $past(link_evt.setup_byte))
      else $error("setup byte eight not shadowed");
   a_shadow_early_skip: assert property (@(posedge clk) disable iff (reset)
      link_evt.setup_byte_valid && link_evt.setup_byte_index < 3'h2
      |=> $stable(s_q.shadow))
      else $error("setup byte one or two reached the shadow");

endmodule : usb_setup_capture_int_mask
`default_nettype wire

/* File: testbench/usb_host_model.sv */
// host side model: drives setup bytes and link events into the block
`timescale 1ns/1ns
`default_nettype none
module usb_host_model
   import usb_setup_pkg::*;
(
   input  wire logic      clk,
   output var  link_evt_s evt
);
   initial evt = '0;
   // -----------------------------------------------------------------
   // setup packet, byte one in bits 7:0; ok low drops the commit
   // -----------------------------------------------------------------
   task automatic setup_packet(input logic [63:0] b, input logic ok);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         evt.setup_byte_valid <= 1'b1;
         evt.setup_byte_index <= 3'(i);
         evt.setup_byte       <= b[8*i+:8];
      end
      @(posedge clk);
      evt.setup_byte_valid <= 1'b0;
      // released data line must not keep showing the last byte
      evt.setup_byte       <= ~b[63:56];
      evt.setup_ok         <= ok;
      @(posedge clk);
      evt.setup_ok         <= 1'b0;
   endtask : setup_packet
   // -----------------------------------------------------------------
   // one-cycle event: 0 nak, 1 endpoint done, 2 ep0 done, 3 sof
   // -----------------------------------------------------------------
   task automatic pulse(input int k, input logic [3:0] ep);
      @(posedge clk);
      evt.nak_sent    <= (k == 0);
      evt.ep_done     <= (k == 1);
      evt.ep0_done    <= (k == 2);
      evt.sof_rx      <= (k == 3);
      evt.nak_ep_num  <= ep;
      evt.ep_done_num <= ep;
      @(posedge clk);
      {evt.nak_sent, evt.ep_done, evt.ep0_done, evt.sof_rx} <= 4'h0;
   endtask : pulse
endmodule : usb_host_model
`default_nettype wire

/* File: testbench/usb_setup_capture_int_mask_tb.sv */
// self-checking bench for the setup capture and interrupt block
`timescale 1ns/1ns
`default_nettype none
module usb_setup_capture_int_mask_tb
   import usb_setup_pkg::*;
;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   apb_req_s    req = '0;
   apb_rsp_s    rsp;
   link_evt_s   evt;
   irq_lines_s  lines;
   logic        irq;
   logic [31:0] rd;
   int          n_errors = 0;
   int          n_checks = 0;
   always #5 clk = ~clk;
   usb_setup_capture_int_mask dut_u (.clk(clk), .reset(reset), .apb_req(req),
      .apb_rsp(rsp), .link_evt(evt), .irq_lines(lines), .irq(irq));
   usb_host_model host_u (.clk(clk), .evt(evt));
   // -----------------------------------------------------------------
   // shared tasks
   // -----------------------------------------------------------------
   task automatic results;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : results
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // holds the request until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge clk);
      req.penable <= 1'b1;
      do @(posedge clk); while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      chk("pslverr", 32'h0000_0000, 32'(rsp.pslverr));
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb
   task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(what, exp, rd);
   endtask : rchk
   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_capture;
      rchk("value after reset", 12'h000, 32'h0000_0000);
      rchk("flags after reset", 12'h00C, 32'h0000_0000);
      host_u.setup_packet(64'h8877_6655_4433_2211, 1'b1);
      rchk("value", 12'h000, 32'h0000_4433);
      rchk("index", 12'h004, 32'h0000_6655);
      rchk("length", 12'h008, 32'h0000_8877);
      host_u.setup_packet(64'hFFEE_DDCC_BBAA_9988, 1'b0);
      apb(1'b1, 12'h000, 32'h0000_FFFF);
      rchk("held length", 12'h008, 32'h0000_8877);
      rchk("held value", 12'h000, 32'h0000_4433);
      host_u.setup_packet(64'h00FF_FF00_00FF_0000, 1'b1);
      rchk("index edge", 12'h004, 32'h0000_FF00);
      rchk("length edge", 12'h008, 32'h0000_00FF);
   endtask : t_capture
   task automatic t_lines;
      logic [3:0] got;
      for (int k = 0; k < 3; k++) begin
         host_u.pulse(k, 4'h1);
         repeat (3) @(posedge clk);
         got = {lines.nak_line, lines.ep_line, lines.ep0_line, 1'b0};
         chk("line open", 32'(4'h8 >> k), 32'(got));
         rchk("flag set", 12'h00C, 32'h80 >> k);
         if (k == 0) rchk("nak record", 12'h010, 32'h0000_0002);
         if (k == 1) rchk("ep record", 12'h014, 32'h0000_0002);
         apb(1'b1, 12'h00C, 32'h8000 >> k);
         repeat (2) @(posedge clk);
         got = {lines.nak_line, lines.ep_line, lines.ep0_line, 1'b0};
         chk("line masked", 32'h0000_0000, 32'(got));
         rchk("flag kept", 12'h00C, (32'h8000 | 32'h80) >> k);
         apb(1'b1, 12'h00C, 32'h80 >> k);
         rchk("flag cleared", 12'h00C, 32'h0000_0000);
         if (k == 0) rchk("nak record clear", 12'h010, 32'h0000_0000);
         if (k == 1) rchk("ep record clear", 12'h014, 32'h0000_0000);
      end
   endtask : t_lines
   task automatic t_irq;
      host_u.pulse(0, 4'h0);
      host_u.pulse(3, 4'h0);
      rchk("frame flag", 12'h00C, 32'h0000_0010);
      chk("irq disabled", 32'h0, 32'(irq));
      apb(1'b1, 12'h018, 32'h0000_0010);
      repeat (2) @(posedge clk);
      chk("irq on", 32'h1, 32'(irq));
      chk("sof line", 32'h1, 32'(lines.sof_line));
      apb(1'b1, 12'h00C, 32'h0000_0010);
      repeat (2) @(posedge clk);
      chk("irq off", 32'h0, 32'(irq));
      rchk("unmapped", 12'h020, 32'h0000_0000);
   endtask : t_irq
   task automatic t_reset;
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rchk("value after mid reset", 12'h000, 32'h0000_0000);
      rchk("index after mid reset", 12'h004, 32'h0000_0000);
      rchk("length after mid reset", 12'h008, 32'h0000_0000);
   endtask : t_reset
   // -----------------------------------------------------------------
   // main sequence and watchdog
   // -----------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      t_capture;
      t_reset;
      t_lines;
      t_irq;
      results;
   end
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      results;
   end
endmodule : usb_setup_capture_int_mask_tb
`default_nettype wire
